/* File: verilog/mwe_pkg.sv */
/*
  Shared constants, types and decode helpers for both ends of the serial
  nonvolatile word store link. Assumes a 10 MHz core clock on each end.
*/
package mwe_pkg;
  localparam int ADDR_W = 9;
  localparam int WORD_W = 8;
  localparam int WORDS = 512;
  localparam int HDR_BITS = 12;
  localparam int FRAME_BITS = 20;
  localparam int CLK_PERIOD_NS = 100;
  localparam int PROG_TIME_NS = 5000000;
  localparam int PROG_CYC = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int MIN_SELECT_LOW_NS = 250;
  localparam int MIN_SELECT_LOW_CYC = (MIN_SELECT_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SK_HALF_CYC = 8;
  localparam int FIFO_DEPTH = 16;
  localparam logic [7:0] ERASED_WORD = 8'hff;
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] SUB_PROGRAM_DISABLE = 2'h0;
  localparam logic [1:0] SUB_FILL_ALL = 2'h1;
  localparam logic [1:0] SUB_CLEAR_ALL = 2'h2;
  localparam logic [1:0] SUB_PROGRAM_ENABLE = 2'h3;

  typedef enum logic [2:0] {
    MWE_D_IDLE = 3'h0, MWE_D_HDR = 3'h1, MWE_D_DATA = 3'h2, MWE_D_READ = 3'h3,
    MWE_D_END = 3'h4, MWE_D_BUSY = 3'h5, MWE_D_PROG = 3'h6
  } mwe_dst_t;

  typedef enum logic [2:0] {
    MWE_H_IDLE = 3'h0, MWE_H_SEND = 3'h1, MWE_H_READ = 3'h2, MWE_H_GAP = 3'h3,
    MWE_H_POLL = 3'h4, MWE_H_CLR = 3'h5
  } mwe_hst_t;

  function automatic logic mwe_has_data(input logic [1:0] op, input logic [1:0] sub);
    return (op == OP_WRITE) || (op == OP_EXT && sub == SUB_FILL_ALL);
  endfunction

  function automatic logic mwe_is_prog(input logic [1:0] op, input logic [1:0] sub);
    return (op == OP_WRITE) || (op == OP_ERASE) ||
           (op == OP_EXT && (sub == SUB_FILL_ALL || sub == SUB_CLEAR_ALL));
  endfunction
endpackage

/* File: verilog/mwe_if.sv */
/*
  Link between host and device: select, serial clock, data in, data out
  with its enable. Assumes a weak pull-down on data out when undriven.
*/
`timescale 1ns/1ps
interface mwe_if;
  logic cs;
  logic sk;
  logic di;
  logic dout;
  logic dout_oe;
  logic do_line;

  // Undriven data out reads low
  assign do_line = dout_oe ? dout : 1'h0;

  modport dev (input cs, input sk, input di, output dout, output dout_oe);
  modport host (output cs, output sk, output di, input do_line);
endinterface

/* File: verilog/mwe_dev.sv */
/*
  Device end: link decoder, 512 x 8 word array, self-timed program engine
  and ready/busy report on data out. Assumes link pins are asynchronous to
  core_clk_i and that the array is cleared or written before it is read.
*/
// Summary of operation
// R1: 4096-bit array of 512 eight-bit words
// R2: DI bits taken on SK rising edge
// R3: DO undriven except read data or status
// R4: Status: DO low busy, high ready
// R5: Clocked 1 while status releases DO
// R6: Host releases DO before driving shared wire
// R7: Frame: start 1, opcode, address, data
// R8: Opcodes 10 read, 11 erase, 01 write
// R9: Opcode 00 sub-commands from top address bits
// R10: Read: dummy zero, then word MSB first
// R11: Held select streams next word, wraps
// R12: Only first streamed word gets dummy zero
// R13: Writes disabled at power-up, enable latch
// R14: Disabled: program instructions ignored
// R15: Reads work regardless of enable latch
// R16: Host holds select low minimum time
// R17: Write: select fall starts clear-and-store
// R18: Self-timed cycle needs no SK edges
// R19: Erase leaves word all ones
// R20: Clear-all leaves every word all ones
// R21: Fill-all writes byte to every word
// R22: Cycle length parameter, busy until expiry
`timescale 1ns/1ps
module mwe_dev #(
  parameter int unsigned PROG_CYCLES = mwe_pkg::PROG_CYC
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  mwe_if.dev link,
  output logic busy_o,
  output logic write_en_o
);

  typedef struct packed {
    mwe_pkg::mwe_dst_t st;
    logic [2:0] cs_s;
    logic [2:0] sk_s;
    logic [2:0] di_s;
    logic cs_f;
    logic sk_f;
    logic di_f;
    logic [3:0] cnt;
    logic [9:0] sh;
    logic [8:0] addr;
    logic [2:0] bit_n;
    logic [7:0] wdata;
    logic job;
    logic all;
    logic wen;
    logic stat;
    logic dout;
    logic oe;
    logic [31:0] tmr;
  } mwe_dstate_t;

  if (PROG_CYCLES < 1) begin : g_chk
    $error("PROG_CYCLES must be at least 1");
  end

  mwe_dstate_t q;
  mwe_dstate_t d;
  logic [7:0] mem [mwe_pkg::WORDS]; // R1
  logic [7:0] rd_word;
  logic [10:0] hdr;
  logic [1:0] op;
  logic [1:0] sub;
  logic sk_rise;
  logic cs_fall;
  logic mem_we;
  logic di_next;

  assign rd_word = mem[q.addr];
  // Filtered data in is worked out apart from d so the decode does not loop through d
  assign di_next = (q.di_s[1] == q.di_s[2]) ? q.di_s[2] : q.di_f;
  assign hdr = {q.sh, di_next};
  assign op = hdr[10:9];
  assign sub = hdr[8:7];

  always_comb begin
    d = q;
    mem_we = 1'h0;
    // Three-stage sampling; a level counts once stages two and three agree
    d.cs_s = {q.cs_s[1:0], link.cs};
    d.sk_s = {q.sk_s[1:0], link.sk};
    d.di_s = {q.di_s[1:0], link.di};
    if (q.cs_s[1] == q.cs_s[2]) begin
      d.cs_f = q.cs_s[2];
    end
    if (q.sk_s[1] == q.sk_s[2]) begin
      d.sk_f = q.sk_s[2];
    end
    d.di_f = di_next;
    sk_rise = d.sk_f & ~q.sk_f & d.cs_f; // R2
    cs_fall = q.cs_f & ~d.cs_f;
    case (q.st)
      mwe_pkg::MWE_D_IDLE: begin
        if (cs_fall) begin
          d.stat = 1'h0;
        end
        if (sk_rise && d.di_f) begin
          if (q.stat) begin
            d.stat = 1'h0; // R5
          end else begin
            d.st = mwe_pkg::MWE_D_HDR; // R7
            d.cnt = 4'h0;
          end
        end
      end
      mwe_pkg::MWE_D_HDR: begin
        if (sk_rise) begin
          d.sh = hdr[9:0];
          d.cnt = q.cnt + 4'h1;
          if (q.cnt == 4'(mwe_pkg::HDR_BITS - 2)) begin
            d.addr = hdr[8:0];
            d.cnt = 4'h0;
            if (op == mwe_pkg::OP_READ) begin
              d.st = mwe_pkg::MWE_D_READ; // R15
              d.oe = 1'h1; // R10
              d.dout = 1'h0; // R12
              d.bit_n = 3'h0;
            end else begin
              d.job = mwe_pkg::mwe_is_prog(op, sub); // R8 R9
              d.all = (op == mwe_pkg::OP_EXT);
              d.wdata = mwe_pkg::ERASED_WORD; // R19 R20
              if (op == mwe_pkg::OP_EXT && sub == mwe_pkg::SUB_PROGRAM_ENABLE) begin
                d.wen = 1'h1; // R13
              end
              if (op == mwe_pkg::OP_EXT && sub == mwe_pkg::SUB_PROGRAM_DISABLE) begin
                d.wen = 1'h0; // R13
              end
              d.st = mwe_pkg::mwe_has_data(op, sub) ? mwe_pkg::MWE_D_DATA : mwe_pkg::MWE_D_END;
            end
          end
        end
      end
      mwe_pkg::MWE_D_DATA: begin
        if (sk_rise) begin
          d.sh = hdr[9:0];
          d.cnt = q.cnt + 4'h1;
          if (q.cnt == 4'(mwe_pkg::WORD_W - 1)) begin
            d.wdata = hdr[7:0]; // R21
            d.st = mwe_pkg::MWE_D_END;
          end
        end
      end
      mwe_pkg::MWE_D_READ: begin
        if (sk_rise) begin
          d.dout = rd_word[~q.bit_n]; // R10
          d.bit_n = q.bit_n + 3'h1;
          if (q.bit_n == 3'h7) begin
            d.addr = q.addr + 9'h001; // R11 R12
          end
        end
      end
      mwe_pkg::MWE_D_END: begin
        if (cs_fall) begin
          if (q.job && q.wen) begin
            d.st = mwe_pkg::MWE_D_BUSY; // R17 R19 R20 R21
            d.tmr = 32'h0;
            d.stat = 1'h1;
            if (q.all) begin
              d.addr = 9'h000;
            end
          end else begin
            d.st = mwe_pkg::MWE_D_IDLE; // R14
          end
        end
      end
      mwe_pkg::MWE_D_BUSY: begin
        d.tmr = q.tmr + 32'h1; // R18
        if (q.tmr == 32'(PROG_CYCLES - 1)) begin
          d.st = mwe_pkg::MWE_D_PROG; // R22
        end
      end
      mwe_pkg::MWE_D_PROG: begin
        mem_we = 1'h1;
        d.addr = q.addr + 9'h001;
        if (!q.all || q.addr == 9'(mwe_pkg::WORDS - 1)) begin
          d.st = mwe_pkg::MWE_D_IDLE;
        end
      end
      default: begin
        d.st = mwe_pkg::MWE_D_IDLE;
      end
    endcase
    if (!d.cs_f && (q.st == mwe_pkg::MWE_D_HDR || q.st == mwe_pkg::MWE_D_DATA ||
                    q.st == mwe_pkg::MWE_D_READ)) begin
      d.st = mwe_pkg::MWE_D_IDLE;
    end
    if ((q.st == mwe_pkg::MWE_D_BUSY || q.st == mwe_pkg::MWE_D_PROG) && sk_rise && d.di_f) begin
      d.stat = 1'h0; // R5
    end
    if (d.st == mwe_pkg::MWE_D_IDLE || d.st == mwe_pkg::MWE_D_BUSY ||
        d.st == mwe_pkg::MWE_D_PROG) begin
      d.oe = d.stat & d.cs_f; // R3 R4
      d.dout = (d.st == mwe_pkg::MWE_D_IDLE); // R4
    end else if (d.st != mwe_pkg::MWE_D_READ) begin
      d.oe = 1'h0; // R3
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Array holds no reset: its contents survive reset like the real store
  always_ff @(posedge core_clk_i) begin
    if (mem_we) begin
      mem[q.addr] <= q.wdata; // R1 R17
    end
  end

  assign link.dout = q.dout;
  assign link.dout_oe = q.oe;
  assign busy_o = (q.st == mwe_pkg::MWE_D_BUSY) || (q.st == mwe_pkg::MWE_D_PROG);
  assign write_en_o = q.wen;

endmodule

/* File: verilog/mwe_fifo.sv */
/*
  Read-data FIFO with valid/ready on both sides. Assumes a power-of-two
  depth and a single clock.
*/
`timescale 1ns/1ps
module mwe_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = mwe_pkg::FIFO_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("DEPTH must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } mwe_fst_t;

  mwe_fst_t q;
  mwe_fst_t d;
  logic [WIDTH-1:0] mem [DEPTH];

  assign in_ready_o = !((q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]));
  assign out_valid_o = (q.wp != q.rp);
  assign out_data_o = mem[q.rp[AW-1:0]];

  always_comb begin
    d = q;
    if (in_valid_i && in_ready_o) begin
      d.wp = q.wp + {{AW{1'h0}}, 1'h1};
    end
    if (out_valid_o && out_ready_i) begin
      d.rp = q.rp + {{AW{1'h0}}, 1'h1};
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (in_valid_i && in_ready_o) begin
      mem[q.wp[AW-1:0]] <= in_data_i;
    end
  end
endmodule

/* File: verilog/mwe_host.sv */
/*
  Host end: frames one instruction per request, makes SK by division,
  streams read words into a FIFO, holds select low, then polls status after an enabled program instruction.
  Assumes the device on the far side of the link interface.
*/
`timescale 1ns/1ps
module mwe_host #(
  parameter int SK_HALF = mwe_pkg::SK_HALF_CYC,
  parameter int CS_LOW = mwe_pkg::MIN_SELECT_LOW_CYC,
  parameter int DEPTH = mwe_pkg::FIFO_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  mwe_if.host link,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [1:0] req_op_i,
  input wire logic [8:0] req_addr_i,
  input wire logic [7:0] req_data_i,
  input wire logic [9:0] req_len_i,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [7:0] rd_data_o,
  output logic busy_o
);
  // Read data returns about eight core cycles after a rise; a shorter half period
  // samples it one bit late. A one-cycle select low is lost in the far end's filter.
  if (SK_HALF < 5 || SK_HALF > 255 || CS_LOW < 2 || CS_LOW > 255) begin : g_chk
    $error("SK_HALF must be 5..255 and CS_LOW 2..255");
  end

  typedef struct packed {
    mwe_pkg::mwe_hst_t st;
    logic [7:0] ph;
    logic cs;
    logic sk;
    logic di;
    logic [19:0] tx;
    logic [4:0] nb;
    logic [3:0] rb;
    logic [7:0] rx;
    logic push;
    logic [9:0] left;
    logic rd;
    logic prog;
    logic wen;
    logic [2:0] do_s;
    logic do_f;
  } mwe_hstate_t;

  mwe_hstate_t q;
  mwe_hstate_t d;
  logic tick;
  logic hd;
  logic fifo_ready;

  always_comb begin
    d = q;
    d.push = 1'h0;
    d.do_s = {q.do_s[1:0], link.do_line};
    if (q.do_s[1] == q.do_s[2]) begin
      d.do_f = q.do_s[2];
    end
    tick = (q.ph == 8'(SK_HALF - 1));
    hd = mwe_pkg::mwe_has_data(req_op_i, req_addr_i[8:7]);
    d.ph = tick ? 8'h00 : q.ph + 8'h01;
    case (q.st)
      mwe_pkg::MWE_H_IDLE: begin
        d.ph = 8'h00;
        if (req_valid_i) begin
          d.tx = {1'h1, req_op_i, req_addr_i, hd ? req_data_i : 8'h00};
          d.nb = hd ? 5'(mwe_pkg::FRAME_BITS) : 5'(mwe_pkg::HDR_BITS);
          d.prog = q.wen & mwe_pkg::mwe_is_prog(req_op_i, req_addr_i[8:7]);
          if (req_op_i == mwe_pkg::OP_EXT) begin
            if (req_addr_i[8:7] == mwe_pkg::SUB_PROGRAM_ENABLE) begin
              d.wen = 1'h1;
            end
            if (req_addr_i[8:7] == mwe_pkg::SUB_PROGRAM_DISABLE) begin
              d.wen = 1'h0;
            end
          end
          d.left = (req_len_i == 10'h000) ? 10'h001 : req_len_i;
          d.rd = (req_op_i == mwe_pkg::OP_READ);
          d.cs = 1'h1;
          d.di = 1'h1;
          d.st = mwe_pkg::MWE_H_SEND;
        end
      end
      mwe_pkg::MWE_H_SEND: begin
        if (tick) begin
          d.sk = ~q.sk;
          if (q.sk) begin
            d.tx = {q.tx[18:0], 1'h0}; // R2 R7
            d.di = q.tx[18];
            d.nb = q.nb - 5'h01;
            if (q.nb == 5'h01) begin
              d.di = 1'h0;
              d.rb = 4'h0;
              d.st = q.rd ? mwe_pkg::MWE_H_READ : mwe_pkg::MWE_H_GAP;
              d.cs = q.rd;
            end
          end
        end
      end
      mwe_pkg::MWE_H_READ: begin
        if (tick) begin
          if (q.sk) begin
            d.sk = 1'h0;
          end else if (q.rb == 4'h8 && (!fifo_ready || q.push)) begin
            d.ph = q.ph;
          end else begin
            if (q.rb != 4'h0) begin
              d.rx = {q.rx[6:0], q.do_f};
            end
            d.rb = q.rb + 4'h1;
            d.sk = 1'h1;
            if (q.rb == 4'h8) begin
              d.push = 1'h1;
              d.left = q.left - 10'h001;
              d.rb = 4'h1;
              if (q.left == 10'h001) begin
                d.sk = 1'h0;
                d.cs = 1'h0;
                d.st = mwe_pkg::MWE_H_GAP;
              end
            end
          end
        end
      end
      mwe_pkg::MWE_H_GAP: begin
        d.ph = q.ph + 8'h01;
        if (q.ph == 8'(CS_LOW - 1)) begin
          d.ph = 8'h00; // R16
          d.rb = 4'h0;
          d.cs = q.prog;
          d.st = q.prog ? mwe_pkg::MWE_H_POLL : mwe_pkg::MWE_H_IDLE;
        end
      end
      mwe_pkg::MWE_H_POLL: begin
        if (tick) begin
          d.rb = 4'h1;
          if (q.rb != 4'h0 && q.do_f) begin
            d.di = 1'h1; // R5 R6
            d.st = mwe_pkg::MWE_H_CLR;
          end
        end
      end
      mwe_pkg::MWE_H_CLR: begin
        if (tick) begin
          d.sk = ~q.sk;
          if (q.sk) begin
            d.di = 1'h0;
            d.cs = 1'h0;
            d.prog = 1'h0;
            d.st = mwe_pkg::MWE_H_GAP;
          end
        end
      end
      default: begin
        d.st = mwe_pkg::MWE_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  mwe_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(q.push),
    .in_data_i(q.rx),
    .in_ready_o(fifo_ready),
    .out_valid_o(rd_valid_o),
    .out_data_o(rd_data_o),
    .out_ready_i(rd_ready_i)
  );

  assign link.cs = q.cs;
  assign link.sk = q.sk;
  assign link.di = q.di;
  assign req_ready_o = (q.st == mwe_pkg::MWE_H_IDLE);
  assign busy_o = (q.st != mwe_pkg::MWE_H_IDLE);
endmodule

/* File: tb/mwe_assertions.sv */
/* Checker on the link signals between the host and device ends.
   Assumes a host serial clock half period of 8 core cycles. */
`timescale 1ns/1ps
module mwe_assertions (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic cs,
  input wire logic sk,
  input wire logic di,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic do_line
);
  logic [11:0] bits_q;
  logic [1:0] op_q;
  logic [3:0] since_q;
  logic sk_q;
  logic rise;
  assign rise = sk && !sk_q;
  // Clock rises since select went high, opcode seen, cycles since last rise
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bits_q <= 12'h000;
      op_q <= 2'h0;
      since_q <= 4'h0;
      sk_q <= 1'b0;
    end else begin
      sk_q <= sk;
      bits_q <= !cs ? 12'h000 : (rise && bits_q != 12'hfff) ? bits_q + 12'h001 : bits_q;
      op_q <= (rise && (bits_q == 12'h001 || bits_q == 12'h002)) ? {op_q[0], di} : op_q;
      since_q <= rise ? 4'h0 : (since_q == 4'hf) ? since_q : since_q + 4'h1;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_di_steady_high: assert property (sk |-> $stable(di))
    else $error("data in moved while serial clock high");
  a_sk_high_time: assert property ($rose(sk) |-> sk[*8] ##1 !sk)
    else $error("serial clock high time wrong");
  a_sk_low_time: assert property ($fell(sk) && cs |-> (!sk)[*8])
    else $error("serial clock low time short");
  a_start_bit_one: assert property (rise && bits_q == 12'h000 |-> di)
    else $error("first bit of a frame is not one");
  a_oe_after_read: assert property (
    rise && bits_q == 12'h00b && op_q == 2'h2 |-> ##[1:8] dout_oe && !dout)
    else $error("no leading zero after read header");
  a_dummy_on_read: assert property ($rose(dout_oe) && bits_q == 12'h00c |-> !dout && op_q == 2'h2)
    else $error("read output did not open with zero");
  a_dout_after_rise: assert property (
    dout_oe && bits_q >= 12'h00c && $changed(dout) |-> since_q <= 4'h7)
    else $error("read data moved without a clock rise");
  a_status_release: assert property (
    rise && di && dout_oe && bits_q == 12'h000 |-> ##[1:8] !dout_oe)
    else $error("status not released by a clocked one");
  a_oe_off_deselect: assert property ($fell(cs) |-> ##[1:8] !dout_oe)
    else $error("data out still driven after deselect");
  a_oe_quiet_idle: assert property ((!cs)[*8] |-> !dout_oe && !do_line)
    else $error("data out driven while deselected");
  c_read_word: cover property ($rose(dout_oe) && bits_q == 12'h00c);
  c_status_drop: cover property (rise && di && dout_oe && bits_q == 12'h000);
  c_write_frame: cover property ($fell(cs) && bits_q == 12'h014);
endmodule

/* File: tb/tb_microwire_eeprom_access.sv */
/* Bench joining host and device ends; drives host requests and checks
   read words against a word model. Assumes the design files compile first. */
`timescale 1ns/1ps
module tb_microwire_eeprom_access;
  localparam int PROG_N = 20;
  logic clk;
  logic rst_n;
  logic req_valid;
  logic req_ready;
  logic [1:0] req_op;
  logic [8:0] req_addr;
  logic [7:0] req_data;
  logic [9:0] req_len;
  logic rd_valid;
  logic rd_ready;
  logic [7:0] rd_data;
  logic h_busy;
  logic d_busy;
  logic wen;
  logic en_m;
  logic [7:0] mem [512];
  int n_mismatch;
  int tests_run;
  int busy_n;

  mwe_if link_if ();
  mwe_dev #(.PROG_CYCLES(PROG_N)) u_mwe_dev (.core_clk_i(clk), .reset_n_i(rst_n),
    .link(link_if.dev), .busy_o(d_busy), .write_en_o(wen));
  mwe_host #(.SK_HALF(8)) u_mwe_host (.core_clk_i(clk), .reset_n_i(rst_n),
    .link(link_if.host), .req_valid_i(req_valid), .req_ready_o(req_ready),
    .req_op_i(req_op), .req_addr_i(req_addr), .req_data_i(req_data), .req_len_i(req_len),
    .rd_valid_o(rd_valid), .rd_ready_i(rd_ready), .rd_data_o(rd_data), .busy_o(h_busy));
  mwe_assertions u_mwe_assertions (.core_clk_i(clk), .reset_n_i(rst_n), .cs(link_if.cs),
    .sk(link_if.sk), .di(link_if.di), .dout(link_if.dout), .dout_oe(link_if.dout_oe),
    .do_line(link_if.do_line));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Sole driver of the busy cycle count; the cmd task takes a snapshot before each command
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_n <= 0;
    end else if (d_busy === 1'b1) begin
      busy_n <= busy_n + 1;
    end
  end

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  task automatic wait_idle;
    int i;
    i = 0;
    @(negedge clk);
    while (req_ready !== 1'b1 && i < 20000) begin
      @(negedge clk);
      i++;
    end
    chk1(req_ready, 1'b1);
  endtask

  // One request handshake; request is taken at the next rising edge
  task automatic send(input logic [1:0] op, input logic [8:0] a, input logic [7:0] d,
                      input int n);
    @(negedge clk);
    req_valid = 1'b1;
    req_op = op;
    req_addr = a;
    req_data = d;
    req_len = 10'(n);
    @(negedge clk);
    req_valid = 1'b0;
  endtask

  task automatic cmd(input logic [1:0] op, input logic [8:0] a, input logic [7:0] d);
    logic prog;
    int k;
    int b0;
    prog = (op != 2'h0) || (a[8:7] == 2'h1) || (a[8:7] == 2'h2);
    b0 = busy_n;
    send(op, a, d, 1);
    if (prog && en_m) begin
      k = 0;
      while (!(link_if.dout_oe === 1'b1 && d_busy === 1'b1) && k < 1000) begin
        @(negedge clk);
        k++;
      end
      chk1(link_if.dout_oe, 1'b1);
      chk1(link_if.dout, 1'b0);
    end
    wait_idle();
    if (prog && en_m) begin
      for (k = 0; k < 512; k++) begin
        if ((op == 2'h0 && a[8:7] == 2'h2) || (op == 2'h3 && k == a)) begin
          mem[k] = 8'hff;
        end else if ((op == 2'h0 && a[8:7] == 2'h1) || (op == 2'h1 && k == a)) begin
          mem[k] = d;
        end
      end
    end
    if (op == 2'h0 && a[8:7] == 2'h3) begin
      en_m = 1'b1;
    end
    if (op == 2'h0 && a[8:7] == 2'h0) begin
      en_m = 1'b0;
    end
    chk1(wen, en_m);
    chk1((busy_n - b0) >= PROG_N, prog && en_m);
    chk1(link_if.dout_oe, 1'b0);
  endtask

  // Burst read; with stall the reader holds off so the buffer fills first
  task automatic rd(input logic [8:0] a, input int n, input int stall);
    int i;
    int j;
    send(2'h2, a, 8'h00, n);
    repeat (stall) @(negedge clk);
    if (stall > 0) begin
      chk1(req_ready, 1'b0);
      chk1(h_busy, 1'b1);
    end
    // Each word is looked at on a falling edge and popped on the next rising edge
    rd_ready = 1'b1;
    for (i = 0; i < n; i++) begin
      j = 0;
      while (rd_valid !== 1'b1 && j < 5000) begin
        @(negedge clk);
        j++;
      end
      chk1(rd_valid, 1'b1);
      chk8(rd_data, mem[(a + i) % 512]);
      @(negedge clk);
    end
    @(negedge clk);
    rd_ready = 1'b0;
    wait_idle();
  endtask

  initial begin
    #(60000 * 100);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_op = 2'h0;
    req_addr = 9'h000;
    req_data = 8'h00;
    req_len = 10'h000;
    rd_ready = 1'b0;
    en_m = 1'b0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    chk1(wen, 1'b0);
    cmd(2'h0, 9'h100, 8'h00);
    cmd(2'h0, 9'h180, 8'h00);
    cmd(2'h0, 9'h100, 8'h00);
    rd(9'h000, 3, 0);
    cmd(2'h0, 9'h080, 8'h5a);
    cmd(2'h1, 9'h005, 8'h3c);
    cmd(2'h3, 9'h006, 8'h00);
    cmd(2'h1, 9'h1ff, 8'h11);
    cmd(2'h1, 9'h000, 8'h22);
    rd(9'h1fe, 4, 0);
    rd(9'h004, 3, 0);
    cmd(2'h0, 9'h000, 8'h00);
    cmd(2'h1, 9'h005, 8'hc3);
    cmd(2'h3, 9'h000, 8'h00);
    cmd(2'h0, 9'h080, 8'h99);
    rd(9'h000, 20, 3000);
    give_verdict();
  end
endmodule
